// ===== rtl/counter_array_map.vh
// register addresses, field positions, reset values and timebase codes
`ifndef COUNTER_ARRAY_MAP_VH
`define COUNTER_ARRAY_MAP_VH

// register bus addresses, both on page zero
`define CA_PAGE 8'h00
`define CA_CONTROL_ADDR 8'hD8
`define CA_MODE_ADDR 8'hD9

// mode register fields
`define MODE_IDLE_HOLD 7
`define MODE_WD_ON 6
`define MODE_WD_LOCK 5
`define MODE_SEL_HI 3
`define MODE_SEL_LO 1
`define MODE_OVF_IRQ_EN 0
`define MODE_RESET 8'h40
`define MODE_WRITE_MASK 8'hEF

// control register fields
`define CTRL_OVF_FLAG 7
`define CTRL_RUN 6

// timebase select codes
`define SEL_DIV12 3'h0
`define SEL_DIV4 3'h1
`define SEL_TIMER0 3'h2
`define SEL_ECI_FALL 3'h3
`define SEL_SYSCLK 3'h4
`define SEL_EXT_DIV8 3'h5

// divider terminal counts
`define DIV12_LAST 4'hB
`define DIV4_LAST 2'h3
`define DIV8_LAST 3'h7

// counter limits
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000

`endif

// ===== rtl/timebase_tick.v
// timebase tick generator for the counter array
`timescale 1ns/100ps
`include "counter_array_map.vh"
module timebase_tick
(
    input wire clock_i,
    input wire rst_n_i,
    input wire [2:0] select_i,
    input wire timer0_ovf_i,
    input wire eci_sync_i,
    input wire ext_clk_sync_i,
    output reg tick_o
);

    reg [3:0] div12; // system clock / 12 prescaler
    reg [1:0] div4; // system clock / 4 prescaler
    reg [2:0] div8; // external clock edge counter
    reg eci_prev; // last synchronised count input
    reg ext_prev; // last synchronised external clock
    wire eci_fall; // high-to-low on count input
    wire ext_rise; // rising edge of external clock

    assign eci_fall = eci_prev & ~eci_sync_i;
    assign ext_rise = ext_clk_sync_i & ~ext_prev;

    // free-running system clock prescalers, external edge counter and edge history
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            div12 <= 4'h0;
            div4 <= 2'h0;
            div8 <= 3'h0;
            eci_prev <= 1'b1;
            ext_prev <= 1'b0;
        end
        else
        begin
            div12 <= (div12 == `DIV12_LAST) ? 4'h0 : div12 + 4'h1;
            div4 <= div4 + 2'h1;
            eci_prev <= eci_sync_i;
            ext_prev <= ext_clk_sync_i;
            // count only external edges
            if (ext_rise)
                div8 <= div8 + 3'h1;
        end
    end

    // one-cycle tick from the selected source
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
            tick_o <= 1'b0;
        else
        begin
            case (select_i)
                `SEL_DIV12: tick_o <= (div12 == `DIV12_LAST); // see R6
                `SEL_DIV4: tick_o <= (div4 == `DIV4_LAST); // see R6
                `SEL_TIMER0: tick_o <= timer0_ovf_i; // see R6
                `SEL_ECI_FALL: tick_o <= eci_fall; // see R7
                `SEL_SYSCLK: tick_o <= 1'b1; // see R8
                `SEL_EXT_DIV8: tick_o <= ext_rise & (div8 == `DIV8_LAST); // see R8
                default: tick_o <= 1'b0; // unused codes stop the count
            endcase
        end
    end

endmodule // timebase_tick

// ===== rtl/counter_array_mode_control.v
// mode control, run control and 16-bit counter of the counter array
//
// Notes on behaviour
// R1: idle_hold_ctl clear: count normally while idle
// R2: idle_hold_ctl set: suspend counting during idle
// R3: watchdog_on makes module 5 the watchdog
// R4: watchdog_lock blocks clearing watchdog_on until reset
// R5: watchdog_on set: other mode bits frozen
// R6: codes 000/001/010: div12, div4, timer0
// R7: code 011: count falling edges of input
// R8: code 100 sysclk, 101 synced external/8
// R9: overflow_irq_enable gates overflow flag onto interrupt
// R10: wrap FFFF to 0000 sets sticky flag
// R11: counter advances only while counter_run set
`timescale 1ns/100ps
`include "counter_array_map.vh"
module counter_array_mode_control
#(
    parameter COUNT_WIDTH = 16
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_page_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire cpu_idle_i,
    input wire timer0_ovf_i,
    input wire external_count_input_i,
    input wire ext_clk_i,
    output wire irq_o,
    output wire watchdog_on_o,
    output reg [COUNT_WIDTH-1:0] count_o
);

    // registers
    reg [7:0] counter_array_mode; // mode register
    reg counter_overflow_flag; // sticky overflow flag
    reg counter_run; // run control

    // pin synchronisers
    reg eci_meta; // first stage, count input
    reg eci_sync; // second stage, count input
    reg ext_meta; // first stage, external clock
    reg ext_sync; // second stage, external clock

    // bus decode
    wire page_hit; // access is on page zero
    wire mode_wr; // write to the mode register
    wire ctrl_wr; // write to the control register
    wire mode_rd; // read of the mode register
    wire ctrl_rd; // read of the control register

    // counting
    wire tick; // timebase tick
    wire idle_stop; // idle hold in force
    wire advance; // counter steps this cycle
    wire wrap; // counter rolls over this cycle

    // next values
    reg [7:0] next_mode; // mode register after a write
    reg next_flag; // overflow flag next value

    // read views
    wire [7:0] ctrl_view; // control register read value
    wire [7:0] mode_view; // mode register read value

    // only page zero and the two addresses of this block answer
    // reads and writes are independent strobes; both may come at once
    assign page_hit = (sfr_page_i == `CA_PAGE);
    assign mode_wr = sfr_wr_i & page_hit & (sfr_addr_i == `CA_MODE_ADDR);
    assign ctrl_wr = sfr_wr_i & page_hit & (sfr_addr_i == `CA_CONTROL_ADDR);
    assign mode_rd = sfr_rd_i & page_hit & (sfr_addr_i == `CA_MODE_ADDR);
    assign ctrl_rd = sfr_rd_i & page_hit & (sfr_addr_i == `CA_CONTROL_ADDR);

    // two flip-flops ahead of any logic on the pins
    // the pins are not timed to this clock; only the second stage is read
    // reset levels are the idle pin levels, so no false edge follows reset
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            eci_meta <= 1'b1;
            eci_sync <= 1'b1;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end
        else
        begin
            // count input, first then second stage
            eci_meta <= external_count_input_i;
            eci_sync <= eci_meta;
            // external clock, first then second stage
            ext_meta <= ext_clk_i;
            ext_sync <= ext_meta;
        end
    end

    // timebase source selection
    // the tick is registered, so a new source takes over one cycle late
    // and a tick already launched from the old source may still land once
    timebase_tick timebase_tick_inst
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .select_i(counter_array_mode[`MODE_SEL_HI:`MODE_SEL_LO]),
        .timer0_ovf_i(timer0_ovf_i),
        .eci_sync_i(eci_sync),
        .ext_clk_sync_i(ext_sync),
        .tick_o(tick)
    );

    // mode register write filtering
    // bit 4 is unused; the mask keeps it zero on every write
    // the lock is applied after the data, so no write can slip past it
    always @*
    begin
        // default: the register keeps its contents
        next_mode = counter_array_mode;
        if (!counter_array_mode[`MODE_WD_ON])
        begin
            // watchdog off: all writable bits take the data
            next_mode = sfr_wdata_i & `MODE_WRITE_MASK;
        end
        else
        begin
            // watchdog on: only the enable bit may move, see R5
            next_mode[`MODE_WD_ON] = sfr_wdata_i[`MODE_WD_ON];
            // lock keeps the watchdog running, see R4
            if (counter_array_mode[`MODE_WD_LOCK])
                next_mode[`MODE_WD_ON] = 1'b1;
        end
    end

    // mode register; once watchdog_on is set, lock only falls with system reset
    // with watchdog_on clear, a mode register write can clear the lock bit
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
            counter_array_mode <= `MODE_RESET; // see R4
        else if (mode_wr)
            counter_array_mode <= next_mode;
    end

    // watchdog function of module 5 follows the enable bit
    // module 5 itself lives outside; this block only grants it the role
    assign watchdog_on_o = counter_array_mode[`MODE_WD_ON]; // see R3

    // idle hold only when the control bit asks for it
    // prescalers run on through idle; only the count step is held back
    // so a tick that falls inside idle is lost rather than delayed
    assign idle_stop = counter_array_mode[`MODE_IDLE_HOLD] & cpu_idle_i; // see R1 see R2
    assign advance = tick & counter_run & ~idle_stop; // see R11
    assign wrap = advance & (count_o == `COUNT_MAX); // see R10

    // the counter itself
    // it wraps on its own; the flag below records the wrap
    // a bus write never moves the count, only a qualified tick does
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
            count_o <= `COUNT_ZERO;
        else if (advance)
            count_o <= count_o + {{(COUNT_WIDTH-1){1'b0}}, 1'b1}; // see R11
    end

    // overflow flag: hardware set wins over a software clear
    // software may also set the flag by writing a one
    // the wrap test comes last, so a clear in the wrap cycle loses
    always @*
    begin
        // default: the flag keeps its state
        next_flag = counter_overflow_flag;
        if (ctrl_wr)
            next_flag = sfr_wdata_i[`CTRL_OVF_FLAG];
        if (wrap)
            next_flag = 1'b1; // see R10
    end

    // control register bits held here
    // the module flags of that register live elsewhere and read zero
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            counter_overflow_flag <= 1'b0;
            counter_run <= 1'b0;
        end
        else
        begin
            counter_overflow_flag <= next_flag;
            // run only moves on a write of the control register
            if (ctrl_wr)
                counter_run <= sfr_wdata_i[`CTRL_RUN]; // see R11
        end
    end

    // interrupt request gated by the enable bit
    // a level request; it falls only when the flag or the enable clears
    assign irq_o = counter_overflow_flag & counter_array_mode[`MODE_OVF_IRQ_EN]; // see R9

    // read views; unused bits read zero
    // views are built from the stored bits, never from the write data
    assign mode_view = counter_array_mode & `MODE_WRITE_MASK;
    assign ctrl_view = {counter_overflow_flag, counter_run, 6'h00};

    // registered read data, one cycle after the strobe
    // a read in the cycle of a write returns the old contents
    // the data stand until the next read strobe of any address
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
            sfr_rdata_o <= 8'h00;
        else if (mode_rd)
            sfr_rdata_o <= mode_view;
        else if (ctrl_rd)
            sfr_rdata_o <= ctrl_view;
        else if (sfr_rd_i)
            sfr_rdata_o <= 8'h00; // unmapped address
    end

endmodule // counter_array_mode_control

// ===== bench/counter_array_mode_checker.sv
// port checker for the counter array mode control
`timescale 1ns/100ps
module counter_array_mode_checker
#(
    parameter COUNT_WIDTH = 16
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_page_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    input wire cpu_idle_i,
    input wire timer0_ovf_i,
    input wire external_count_input_i,
    input wire ext_clk_i,
    input wire irq_o,
    input wire watchdog_on_o,
    input wire [COUNT_WIDTH-1:0] count_o
);
    // decoded page zero accesses
    wire rd_md = sfr_rd_i && sfr_page_i == 8'h00 && sfr_addr_i == 8'hD9;
    wire rd_ct = sfr_rd_i && sfr_page_i == 8'h00 && sfr_addr_i == 8'hD8;
    wire wr_hit = sfr_wr_i && sfr_page_i == 8'h00;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    reset_state_a: assert property ($rose(rst_n_i) |-> watchdog_on_o && !irq_o
        && count_o == 0 && sfr_rdata_o == 8'h00) else $error("bad reset state");
    count_step_a: assert property ($past(rst_n_i) && count_o != $past(count_o)
        |-> count_o == $past(count_o) + 1'b1) else $error("count jumped");
    wd_read_a: assert property (rd_md |=> sfr_rdata_o[6] == $past(watchdog_on_o)
        && !sfr_rdata_o[4]) else $error("mode readback wrong");
    ctl_read_a: assert property (rd_ct |=> sfr_rdata_o[5:0] == 6'h00)
        else $error("control low bits not zero");
    miss_read_a: assert property (sfr_rd_i && !rd_md && !rd_ct |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property ($past(rst_n_i) && !$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
        else $error("read data moved");
    wd_fall_a: assert property ($fell(watchdog_on_o)
        |-> $past(wr_hit && sfr_addr_i == 8'hD9 && !sfr_wdata_i[6])) else $error("wd off");
    wd_rise_a: assert property ($past(rst_n_i) && $rose(watchdog_on_o)
        |-> $past(wr_hit && sfr_addr_i == 8'hD9)) else $error("wd on uncaused");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(wr_hit)
        || (count_o == 0 && &$past(count_o))) else $error("irq uncaused");
    irq_fall_a: assert property ($past(rst_n_i) && $fell(irq_o) |-> $past(wr_hit))
        else $error("irq dropped");
endmodule // counter_array_mode_checker
bind counter_array_mode_control counter_array_mode_checker #(.COUNT_WIDTH(COUNT_WIDTH)) chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i), .timer0_ovf_i(timer0_ovf_i),
    .external_count_input_i(external_count_input_i), .ext_clk_i(ext_clk_i),
    .irq_o(irq_o), .watchdog_on_o(watchdog_on_o), .count_o(count_o));

// ===== bench/counter_array_mode_control_test.sv
// self-checking bench for the counter array mode control
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected t=%0t got %h want %h", $time, a, b); end end
module counter_array_mode_control_test;
    logic clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, idle = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, page = 8'h00;
    wire [7:0] rdata;
    wire irq, wd_on;
    wire [15:0] count_o;
    int cyc = 0, n_mismatch = 0, cmp_count = 0, p;
    // tick period per timebase code, 0 means no count
    int per_tab[8] = '{12, 4, 5, 4, 1, 16, 0, 0};
    always #5 clock_i = ~clock_i;
    counter_array_mode_control counter_array_mode_control_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_page_i(page),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .cpu_idle_i(idle), .timer0_ovf_i(cyc % 5 == 0), .external_count_input_i(cyc[1]),
        .ext_clk_i(cyc[0]), .irq_o(irq), .watchdog_on_o(wd_on), .count_o(count_o));
    // sources and hang guard; the whole run needs about 66000 cycles
    always @(negedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clock_i);
        wr = 0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_i);
        addr = a;
        rd = 1;
        @(negedge clock_i);
        rd = 0;
        `CHK(rdata, e)
    endtask
    // cycles between two counter steps, 0 if none
    task automatic per(output int n);
        logic [15:0] c;
        n = 0;
        // pass two steps first: one may still come from the old source
        for (int k = 0; k < 2; k++)
        begin
            c = count_o;
            for (int i = 0; i < 40 && count_o === c; i++) @(negedge clock_i);
        end
        c = count_o;
        for (int i = 1; i < 40 && n == 0; i++)
        begin
            @(negedge clock_i);
            if (count_o !== c) n = i;
        end
    endtask
    initial
    begin
        repeat (5) @(negedge clock_i);
        rst_n_i = 1;
        rd_chk(8'hD9, 8'h40);
        wr_reg(8'hD9, 8'h4A);
        rd_chk(8'hD9, 8'h40);
        wr_reg(8'hD9, 8'h0A);
        rd_chk(8'hD9, 8'h00);
        `CHK(wd_on, 1'b0)
        wr_reg(8'hD8, 8'h40);
        for (int s = 0; s < 8; s++)
        begin
            wr_reg(8'hD9, 8'(s * 2));
            per(p);
            `CHK(p, per_tab[s])
        end
        wr_reg(8'hD9, 8'h08);
        idle = 1;
        per(p);
        `CHK(p, 1)
        wr_reg(8'hD9, 8'h88);
        per(p);
        `CHK(p, 0)
        idle = 0;
        per(p);
        `CHK(p, 1)
        wr_reg(8'hD8, 8'h00);
        per(p);
        `CHK(p, 0)
        wr_reg(8'hD9, 8'h09);
        wr_reg(8'hD8, 8'h40);
        while (count_o !== 16'hFFFF) @(negedge clock_i);
        `CHK(irq, 1'b0)
        @(negedge clock_i);
        `CHK(irq, 1'b1)
        wr_reg(8'hD8, 8'h80);
        rd_chk(8'hD8, 8'h80);
        wr_reg(8'hD9, 8'h08);
        `CHK(irq, 1'b0)
        wr_reg(8'hD8, 8'h00);
        rd_chk(8'hD8, 8'h00);
        page = 8'h0F;
        rd_chk(8'hD9, 8'h00);
        page = 8'h00;
        wr_reg(8'hD9, 8'h60);
        wr_reg(8'hD9, 8'h00);
        rd_chk(8'hD9, 8'h60);
        `CHK(wd_on, 1'b1)
        rst_n_i = 0;
        repeat (5) @(negedge clock_i);
        rst_n_i = 1;
        wr_reg(8'hD9, 8'h00);
        rd_chk(8'hD9, 8'h00);
        close_out();
    end
endmodule // counter_array_mode_control_test
